/* core/sfs_pkg.sv */
package sfs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int OSC_DIV = 4;
  localparam int DEB_TIME_NS = 800;
  localparam int DEB_CYC = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] PH_TICK = 2'(OSC_DIV - 1);
  localparam logic [1:0] PH_FALL = 2'h1;

  // ----------------------------------------------------------------
  // Fetch cycle slots
  // ----------------------------------------------------------------
  localparam logic [3:0] LOAD_SLOT = 4'hc;
  localparam logic [3:0] IR_SLOTS = 4'h8;
  localparam logic [3:0] BLK_FIRST = 4'h7;
  localparam logic [3:0] BLK_MID = 4'h8;
  localparam logic [3:0] BLK_LAST = 4'h9;

  // ----------------------------------------------------------------
  // Reset values and vectors
  // ----------------------------------------------------------------
  localparam logic [11:0] FP_RESET = 12'h000;
  localparam logic [11:0] CNT_PRESET = 12'hfff;
  localparam logic [11:0] RET_MARK = 12'hfff;
  localparam logic [3:0][11:0] JAM_VEC = {12'h008, 12'h006, 12'h004,
                                          12'h002};

  // ----------------------------------------------------------------
  // Instruction fields and codes
  // ----------------------------------------------------------------
  localparam int F_GROUP = 15;
  localparam int F_OPER = 12;
  localparam int F_TC = 11;
  localparam int F_NA = 6;
  localparam int F_TEMP = 4;
  localparam logic [2:0] OP_IDLE = 3'h0;
  localparam logic [2:0] OP_LC1 = 3'h1;
  localparam logic [2:0] OP_LC2 = 3'h2;
  localparam logic [2:0] OP_LC3 = 3'h3;
  localparam logic [2:0] OP_LC4 = 3'h4;
  localparam logic [2:0] OP_JMP_RET = 3'h5;
  localparam logic [2:0] OP_CALL = 3'h6;
  localparam logic [2:0] LOP_LD = 3'h0;
  localparam logic [2:0] LOP_AND = 3'h1;
  localparam logic [2:0] LOP_OR = 3'h2;
  localparam logic [2:0] LOP_XOR = 3'h3;
  localparam logic [2:0] LOP_STR = 3'h6;
  localparam logic [2:0] LOP_SET = 3'h7;
  localparam logic [4:0] NA_CZ_BASE = 5'h0c;
  localparam logic [4:0] NA_M_BASE = 5'h10;
  localparam logic [4:0] NA_T_BASE = 5'h1c;

  // Fetched instruction with the address of its low byte
  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] insn;
  } sfs_word_t;

endpackage : sfs_pkg

/* core/sfs_skid2.sv */
`timescale 1ns/1ns
module sfs_skid2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic wr_en;
  logic rd_en;

  // Honest flags straight from the occupancy count
  assign o_ready = (cnt_q != (PW+1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data = mem_q[rd_q];
  assign wr_en = i_valid & o_ready;
  assign rd_en = o_valid & i_ready;

  // Pointers and count; flush drops stale words after a redirect
  always_ff @(posedge i_clk) begin
    if (i_rst || i_flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (wr_en) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (rd_en) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(wr_en) - (PW+1)'(rd_en);
    end
  end

  // Storage needs no reset, the count guards it
  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      mem_q[wr_q] <= i_data;
    end
  end

endmodule : sfs_skid2

/* core/sfs_sequencer.sv */
// Notes on behaviour
// - Reset clears the fetch pointer so the first fetch reads location 0.
// - Fetch cycle is 13 shift clocks: 12 with load low, one high.
// - The fetch pointer steps by one every fetch cycle.
// - Opcode register shifts only on the first eight clocks of a cycle.
// - Low byte first, then high byte; execute after the high byte.
// - Program bits arrive least significant bit first.
// - Address goes out MSB first, changing at shift clock rise.
// - Four 12-bit down counters: loaded by program, decremented both ways.
// - Counter ops block that count input from clock 8 to clock 10.
// - Count pulses during the block are held, not lost.
// - Each rising count input edge decrements its counter once.
// - Master clear stops clock, clears state, presets counters to ones.
// - Internal shift timing is the input clock divided by four.
// - Interrupt edge forces vector 2, 4, 6 or 8 after the instruction.
// - Only interrupt one pushes the return address on the stack.
// - Request latch set by rising edge, cleared when serviced.
// - A high interrupt input holds off all lower priority requests.
// - Lower requests wait until the higher input returns low.
// - Interrupt, count and switch inputs are debounced internally.
// - Control group: idle code and counter loads one to three.
// - A counter load with zero constant decrements that counter.
// - Code 100 loads counter four.
// - Code 110 pushes the return address and jumps.
// - Return stack holds three levels, last in first out.
`timescale 1ns/1ns
module sfs_sequencer
  import sfs_pkg::*;
#(
  parameter int DEB_CYCLES = DEB_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_master_clear_pin,
  input wire logic i_program_serial_in,
  input wire logic [3:0] i_vectored_interrupt_input,
  input wire logic [3:0] i_count_pulse_input,
  input wire logic [11:0] i_switch_sense_input,
  input wire logic i_exec_hold,
  output logic o_shift_clk,
  output logic o_shift_load,
  output logic o_address,
  output logic [11:0] o_latched_output_bit,
  output logic o_boolean_accumulator_flag,
  output logic [11:0] o_fetch_pointer
);

  // ----------------------------------------------------------------
  // Synchronisers and debounce
  // ----------------------------------------------------------------
  logic ms1_q, ms2_q, is1_q, is2_q, clr;
  logic [19:0] raw, deb;
  logic [3:0] jam_lvl, cnt_lvl, jam_prv_q, cnt_prv_q, jam_rise, cnt_rise;
  logic [11:0] di;

  assign clr = i_sys_rst | ms2_q;
  assign raw = {i_switch_sense_input, i_count_pulse_input,
                i_vectored_interrupt_input};

  // Pin synchronisers for master clear and the program stream
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ms1_q <= 1'b0;
      ms2_q <= 1'b0;
      is1_q <= 1'b0;
      is2_q <= 1'b0;
    end else begin
      ms1_q <= i_master_clear_pin;
      ms2_q <= ms1_q;
      is1_q <= i_program_serial_in;
      is2_q <= is1_q;
    end
  end

  // A level must hold for the whole window before it is believed
  for (genvar g = 0; g < 20; g++) begin : g_deb
    logic s1_q, s2_q, d_q;
    logic [4:0] c_q;
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        d_q <= 1'b0;
        c_q <= 5'h00;
      end else begin
        s1_q <= raw[g];
        s2_q <= s1_q;
        if (s2_q == d_q) begin
          c_q <= 5'h00;
        end else if (c_q == 5'(DEB_CYCLES - 1)) begin
          d_q <= s2_q;
          c_q <= 5'h00;
        end else begin
          c_q <= c_q + 5'h01;
        end
      end
    end
    assign deb[g] = d_q;
  end

  assign jam_lvl = deb[3:0];
  assign cnt_lvl = deb[7:4];
  assign di = deb[19:8];
  assign jam_rise = jam_lvl & ~jam_prv_q;
  assign cnt_rise = cnt_lvl & ~cnt_prv_q;

  // Edge history of the debounced levels
  always_ff @(posedge i_clk) begin
    if (clr) begin
      jam_prv_q <= 4'h0;
      cnt_prv_q <= 4'h0;
    end else begin
      jam_prv_q <= jam_lvl;
      cnt_prv_q <= cnt_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Fetch sequencer
  // ----------------------------------------------------------------
  logic [1:0] ph_q;
  logic [3:0] slot_q;
  logic go_q, clk_q, ld_q, tick, start, cyc_end, sample, push;
  logic [11:0] ash_q, fp_q, sent_q, in_addr_q, lo_addr_q;
  logic in_valid_q, lo_ok_q, buf_in_ready, redir;
  logic [15:0] ir_q;
  logic [11:0] target;

  assign tick = (ph_q == PH_TICK);
  assign start = tick & (~go_q | (slot_q == LOAD_SLOT)) & buf_in_ready;
  assign cyc_end = tick & go_q & (slot_q == LOAD_SLOT);
  assign sample = go_q & (ph_q == PH_FALL) & (slot_q < IR_SLOTS);
  assign push = cyc_end & in_valid_q & in_addr_q[0] & lo_ok_q;

  // Divide by four; clear holds the divider so the shift clock stops
  always_ff @(posedge i_clk) begin
    if (clr) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
    end
  end

  // Slot counter, shift clock and shift/load; a full buffer parks slot 0
  always_ff @(posedge i_clk) begin
    if (clr || redir) begin
      slot_q <= 4'h0;
      go_q <= 1'b0;
      clk_q <= 1'b0;
      ld_q <= 1'b0;
    end else if (tick) begin
      if (go_q && slot_q != LOAD_SLOT) begin
        slot_q <= slot_q + 4'h1;
        ld_q <= (slot_q + 4'h1 == LOAD_SLOT);
        clk_q <= 1'b1;
      end else begin
        slot_q <= 4'h0;
        go_q <= buf_in_ready;
        ld_q <= 1'b0;
        clk_q <= buf_in_ready;
      end
    end else if (ph_q == PH_FALL) begin
      clk_q <= 1'b0;
    end
  end

  // Address shifter and fetch pointer
  always_ff @(posedge i_clk) begin
    if (clr) begin
      ash_q <= 12'h000;
      fp_q <= FP_RESET;
      sent_q <= 12'h000;
    end else if (redir) begin
      fp_q <= target;
    end else if (start) begin
      ash_q <= fp_q;
      sent_q <= fp_q;
      fp_q <= fp_q + 12'h001;
    end else if (tick && go_q && (slot_q + 4'h1) < LOAD_SLOT) begin
      ash_q <= {ash_q[10:0], 1'b0};
    end
  end

  // Track what the external register holds; a redirect makes it stale
  always_ff @(posedge i_clk) begin
    if (clr || redir) begin
      in_valid_q <= 1'b0;
      in_addr_q <= 12'h000;
      lo_ok_q <= 1'b0;
      lo_addr_q <= 12'h000;
    end else if (cyc_end) begin
      in_valid_q <= 1'b1;
      in_addr_q <= sent_q;
      lo_ok_q <= in_valid_q & ~in_addr_q[0];
      if (in_valid_q && !in_addr_q[0]) begin
        lo_addr_q <= in_addr_q;
      end
    end
  end

  // Bits enter at the top and move down: LSB first
  always_ff @(posedge i_clk) begin
    if (clr) begin
      ir_q <= 16'h0000;
    end else if (sample) begin
      ir_q <= {is2_q, ir_q[15:1]};
    end
  end

  // ----------------------------------------------------------------
  // Instruction buffer
  // ----------------------------------------------------------------
  sfs_word_t push_word, bw;
  logic bv, pop;

  assign push_word = '{addr: lo_addr_q, insn: ir_q};
  assign pop = bv & ~i_exec_hold;

  sfs_skid2 #(.W($bits(sfs_word_t)), .DEPTH(2)) u_buf (
    .i_clk(i_clk),
    .i_rst(clr),
    .i_flush(redir),
    .i_valid(push),
    .o_ready(buf_in_ready),
    .i_data(push_word),
    .o_valid(bv),
    .i_ready(~i_exec_hold),
    .o_data(bw)
  );

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  logic [3:0][11:0] cnt_q;
  logic [2:0][11:0] st_q, st_d;
  logic [3:0] jrr_q, jrr_clr, irq_sel, ex_we, pend_q, blk, ext_dec;
  logic [11:0] lo_q, lo_d, m_q, m_d, ex_val, nxt, ret_eff, n;
  logic [2:0] t_q, t_d, op;
  logic [4:0] na;
  logic [3:0] disp;
  logic [1:0] cidx, tsel;
  logic af_q, af_d, opnd, val, lu, tc, found;

  assign n = bw.insn[11:0];
  assign op = bw.insn[F_OPER +: 3];
  assign tc = bw.insn[F_TC];
  assign na = bw.insn[F_NA +: 5];
  assign tsel = bw.insn[F_TEMP +: 2];
  assign disp = bw.insn[3:0];
  assign cidx = op[1:0] - 2'h1;
  assign nxt = bw.addr + 12'h002;

  // Decode and side effects of one popped instruction
  always_comb begin
    st_d = st_q;
    af_d = af_q;
    t_d = t_q;
    m_d = m_q;
    lo_d = lo_q;
    ex_we = 4'h0;
    ex_val = 12'h000;
    redir = 1'b0;
    target = fp_q;
    jrr_clr = 4'h0;
    irq_sel = 4'h0;
    found = 1'b0;
    opnd = 1'b0;
    lu = af_q;
    if (na < NA_CZ_BASE) begin
      opnd = di[na[3:0]];
    end else if (na < NA_M_BASE) begin
      opnd = (cnt_q[na[1:0]] == 12'h000);
    end else if (na < NA_T_BASE) begin
      opnd = m_q[na[3:0]];
    end else if (na[1:0] != 2'h3) begin
      opnd = t_q[na[1:0]];
    end
    val = opnd ^ tc;
    if (pop && !bw.insn[F_GROUP]) begin
      unique case (op)
        OP_IDLE: begin
        end
        OP_LC1, OP_LC2, OP_LC3, OP_LC4: begin
          ex_we[cidx] = 1'b1;
          ex_val = (n == 12'h000) ? cnt_q[cidx] - 12'h001 : n;
        end
        OP_JMP_RET: begin
          redir = 1'b1;
          if (n == RET_MARK) begin
            target = st_d[0];
            st_d[0] = st_d[1];
            st_d[1] = st_d[2];
          end else begin
            target = n;
          end
        end
        OP_CALL: begin
          st_d[2] = st_d[1];
          st_d[1] = st_d[0];
          st_d[0] = nxt;
          target = n;
          redir = 1'b1;
        end
        default: begin
        end
      endcase
    end else if (pop) begin
      unique case (op)
        LOP_LD: lu = val;
        LOP_AND: lu = af_q & val;
        LOP_OR: lu = af_q | val;
        LOP_XOR: lu = af_q ^ val;
        LOP_STR, LOP_SET: begin
          if (na < NA_CZ_BASE) begin
            lo_d[na[3:0]] = (op == LOP_STR) ? af_q ^ tc : ~tc;
          end else if (na >= NA_M_BASE && na < NA_T_BASE) begin
            m_d[na[3:0]] = (op == LOP_STR) ? af_q ^ tc : ~tc;
          end
        end
        default: lu = af_q;
      endcase
      if (!op[2]) begin
        af_d = lu;
      end
      if (tsel != 2'h0) begin
        t_d[tsel - 2'h1] = lu;
      end
      if (!lu && disp != 4'h0) begin
        redir = 1'b1;
        target = nxt + {{7{disp[3]}}, disp, 1'b0};
      end
    end
    ret_eff = redir ? target : nxt;
    // Interrupts are taken only at an instruction boundary
    if (pop) begin
      for (int i = 0; i < 4; i++) begin
        if (!found && jrr_q[i] &&
            (jam_lvl & ((4'h1 << i) - 4'h1)) == 4'h0) begin
          found = 1'b1;
          irq_sel[i] = 1'b1;
          target = JAM_VEC[i];
          redir = 1'b1;
        end
      end
      if (irq_sel[0]) begin
        st_d[2] = st_d[1];
        st_d[1] = st_d[0];
        st_d[0] = ret_eff;
      end
      jrr_clr = irq_sel;
    end
  end

  // Program-visible flags, outputs and the stack
  always_ff @(posedge i_clk) begin
    if (clr) begin
      af_q <= 1'b0;
      t_q <= 3'h0;
      m_q <= 12'h000;
      lo_q <= 12'h000;
      st_q <= '0;
    end else begin
      af_q <= af_d;
      t_q <= t_d;
      m_q <= m_d;
      lo_q <= lo_d;
      st_q <= st_d;
    end
  end

  // Request latches: a new edge wins over a service clear
  always_ff @(posedge i_clk) begin
    if (clr) begin
      jrr_q <= 4'h0;
    end else begin
      jrr_q <= jam_rise | (jrr_q & ~jrr_clr);
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  logic blk_win, blk_any;

  // Window from the fall of shift clock 8 to the fall of clock 10
  assign blk_win = go_q & in_valid_q & in_addr_q[0] & ~ir_q[F_GROUP] &
                   ((slot_q == BLK_FIRST && ph_q > PH_FALL) ||
                    slot_q == BLK_MID ||
                    (slot_q == BLK_LAST && ph_q <= PH_FALL));
  for (genvar k = 0; k < 4; k++) begin : g_blk
    assign blk[k] = blk_win & (ir_q[F_OPER +: 3] == 3'(k + 1));
  end
  assign blk_any = |blk;
  assign ext_dec = (pend_q | cnt_rise) & ~(blk | ex_we);

  // Held pulses are released once the block or the write is over
  always_ff @(posedge i_clk) begin
    if (clr) begin
      cnt_q <= {4{CNT_PRESET}};
      pend_q <= 4'h0;
    end else begin
      pend_q <= (pend_q | cnt_rise) & (blk | ex_we);
      for (int i = 0; i < 4; i++) begin
        if (ex_we[i]) begin
          cnt_q[i] <= ex_val;
        end else if (ext_dec[i]) begin
          cnt_q[i] <= cnt_q[i] - 12'h001;
        end
      end
    end
  end

  assign o_shift_clk = clk_q;
  assign o_shift_load = ld_q;
  assign o_address = ash_q[11];
  assign o_latched_output_bit = lo_q;
  assign o_boolean_accumulator_flag = af_q;
  assign o_fetch_pointer = fp_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_load_period;
    o_shift_load [*4] ##1 !o_shift_load;
  endsequence
  sequence s_block_period;
    blk_any [*8] ##1 !blk_any;
  endsequence

  a_clear_ptr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ms2_q |=> fp_q == FP_RESET) else $error("pointer not cleared");
  a_load_one_clock: assert property (@(posedge i_clk)
    disable iff (clr || redir) $rose(o_shift_load) |-> s_load_period)
    else $error("shift/load high not one shift clock");
  a_ptr_step: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    start && !redir && !clr |=> fp_q == $past(fp_q) + 12'h001)
    else $error("pointer did not step by one");
  a_ir_gated: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !$stable(ir_q) |-> $past(sample) || $past(clr))
    else $error("opcode register clocked outside first eight");
  a_word_pairs: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    push |-> lo_addr_q + 12'h001 == in_addr_q)
    else $error("word not low then high byte");
  a_addr_msb: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    start && !redir && !clr |=> o_address == $past(fp_q[11]))
    else $error("address MSB not first");
  a_block_len: assert property (@(posedge i_clk)
    disable iff (clr || redir) $rose(blk_any) |-> s_block_period)
    else $error("count block not two shift clocks");
  a_count_dec: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ext_dec[0] && !clr |=> cnt_q[0] == $past(cnt_q[0]) - 12'h001)
    else $error("counter did not decrement once");
  a_clear_state: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ms2_q |=> cnt_q == {4{CNT_PRESET}} && lo_q == 12'h000 && jrr_q == 4'h0)
    else $error("master clear state wrong");
  a_jam_vector: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    pop && irq_sel[1] && !clr |=> fp_q == JAM_VEC[1])
    else $error("interrupt two vector wrong");
  a_jam1_push: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    pop && irq_sel[0] && !clr |=> st_q[0] == $past(ret_eff))
    else $error("return address not pushed");
  a_jam_inhibit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    irq_sel[3] |-> jam_lvl[2:0] == 3'h0)
    else $error("lower request served under high input");

endmodule : sfs_sequencer

/* testbench/sfs_prog_mem_model.sv */
`timescale 1ns/1ns
module sfs_prog_mem_model (
  input wire logic i_shift_clk,
  input wire logic i_shift_load,
  input wire logic i_address,
  output logic o_serial,
  output logic [11:0] o_last_addr,
  output logic [15:0] o_loads,
  output logic [4:0] o_gap
);
  // ----------------------------------------------------------------
  // Byte-wide program memory behind a 12-bit interface register
  // ----------------------------------------------------------------
  logic [7:0] mem [0:4095] = '{default: 8'h00};
  logic [11:0] addr_q = 12'h000;
  logic [7:0] data_q = 8'h00;
  logic [4:0] cnt_q = 5'h00;

  // Load count and gap let the bench see each fetch cycle
  initial begin
    o_last_addr = 12'h000;
    o_loads = 16'h0000;
    o_gap = 5'h00;
  end

  // Full 12 bits kept, so no high address bit is lost here
  always @(negedge i_shift_clk) begin
    if (i_shift_load) begin
      data_q <= mem[addr_q];
      o_last_addr <= addr_q;
      o_loads <= o_loads + 16'h0001;
      o_gap <= cnt_q + 5'h01;
      cnt_q <= 5'h00;
    end else begin
      addr_q <= {addr_q[10:0], i_address};
      data_q <= {1'b0, data_q[7:1]}; // Pull-down fills emptied bits
      cnt_q <= cnt_q + 5'h01;
    end
  end

  assign o_serial = data_q[0];
endmodule : sfs_prog_mem_model

/* testbench/test_sfs_sequencer.sv */
`timescale 1ns/1ns
module test_sfs_sequencer;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic master_clear_pin = 1'b0;
  logic [3:0] vectored_interrupt_input = 4'h0;
  logic [3:0] cnt_in = 4'h0;
  logic [11:0] sw = 12'h000;
  logic hold = 1'b0;
  logic churn = 1'b1;
  logic pulse = 1'b0;
  logic af;
  logic serial, sclk, sload, saddr;
  logic [11:0] lo, fp, last_addr;
  logic [15:0] loads, seen;
  logic [4:0] gap;
  int mismatches = 0;
  int checks = 0;
  int seed = 5483;
  int r1, r2, i;

  initial begin
    forever #20 i_clk = ~i_clk;
  end

  // Short debounce keeps the run brief
  sfs_sequencer #(.DEB_CYCLES(3)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_master_clear_pin(master_clear_pin), .i_program_serial_in(serial),
    .i_vectored_interrupt_input(vectored_interrupt_input),
    .i_count_pulse_input(cnt_in | {3'h0, pulse}),
    .i_switch_sense_input(sw), .i_exec_hold(hold), .o_shift_clk(sclk),
    .o_shift_load(sload), .o_address(saddr), .o_latched_output_bit(lo),
    .o_boolean_accumulator_flag(af), .o_fetch_pointer(fp));

  sfs_prog_mem_model mem_u (.i_shift_clk(sclk), .i_shift_load(sload),
    .i_address(saddr), .o_serial(serial), .o_last_addr(last_addr),
    .o_loads(loads), .o_gap(gap));

  // Slow random churn on switches and count pins; off for counter tests
  always @(posedge i_clk) begin
    if (!churn) begin
      cnt_in <= 4'h0;
    end else if (($random(seed) & 63) == 0) begin
      sw <= 12'($random(seed));
      cnt_in <= 4'($random(seed));
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] set_word(input int r);
    return 16'hf000 | 16'(r << 6);
  endfunction : set_word

  function automatic logic [11:0] vec(input int k);
    return 12'(2 * k + 2);
  endfunction : vec

  task automatic put(input int a, input logic [15:0] w);
    mem_u.mem[a] = w[7:0];
    mem_u.mem[a + 1] = w[15:8];
  endtask : put

  task automatic chk(input string n, input logic [11:0] e,
                     input logic [11:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Bounded wait for the memory to load a given address
  task automatic wait_load(input logic [11:0] a, input bit gchk);
    int n;
    bit hit;
    hit = 1'b0;
    for (n = 0; n < 8000 && !hit; n++) begin
      @(posedge i_clk);
      if (loads !== seen) begin
        seen = loads;
        hit = (last_addr === a);
      end
    end
    checks++;
    if (!hit) begin
      mismatches++;
      $display("wrong value load address expected %h seen %h", a, last_addr);
      test_done();
    end
    if (gchk) begin
      chk("shift clocks per cycle", 12'h00d, 12'(gap));
    end
  endtask : wait_load

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seen = 16'h0000;
    r1 = $unsigned($random(seed)) % 12;
    r2 = $unsigned($random(seed)) % 12;
    put(0, set_word(r1));
    put(32, 16'h6080);
    put(128, set_word(r2));
    put(130, 16'h5fff);
    put(96, 16'h5010);
    put(40, 16'h1001);
    put(42, 16'h1000);
    put(44, 16'h8300);
    repeat (10) @(posedge i_clk);
    chk("fetch pointer", 12'h000, fp);
    chk("latched outputs", 12'h000, lo);
    i_sys_rst <= 1'b0;
    wait_load(12'h000, 1'b0);
    for (i = 1; i < 6; i++) begin
      wait_load(12'(i), 1'b1);
    end
    $display("test fetch done");
    wait_load(12'h010, 1'b0);
    chk("set output", 12'h001 << r1, lo);
    wait_load(12'h080, 1'b0);
    wait_load(12'h022, 1'b0);
    chk("called output", (12'h001 << r1) | (12'h001 << r2), lo);
    $display("test program done");
    // Stall the drain long enough to fill both buffer entries
    hold <= 1'b1;
    repeat (400 + ($unsigned($random(seed)) % 64)) @(posedge i_clk);
    chk("parked shift clock", 12'h000, 12'(sclk));
    hold <= 1'b0;
    wait_load(12'h040, 1'b0);
    $display("test stall done");
    // Counter one loaded with one, decremented, zero flag read into AF
    churn <= 1'b0;
    wait_load(12'h030, 1'b0);
    wait_load(12'h030, 1'b0);
    chk("zero flag", 12'h001, 12'(af));
    // One count pulse between the decrement and the flag read
    wait_load(12'h02c, 1'b0);
    repeat (8) @(posedge i_clk);
    pulse <= 1'b1;
    repeat (8) @(posedge i_clk);
    pulse <= 1'b0;
    wait_load(12'h030, 1'b0);
    chk("counted past zero", 12'h000, 12'(af));
    churn <= 1'b1;
    $display("test counter done");
    // Lowest first, so a vector is never reached by plain flow
    for (i = 3; i >= 0; i--) begin
      vectored_interrupt_input[i] <= 1'b1;
      wait_load(vec(i), 1'b0);
      vectored_interrupt_input[i] <= 1'b0;
      repeat (20) @(posedge i_clk);
    end
    $display("test interrupt done");
    master_clear_pin <= 1'b1;
    repeat (10) @(posedge i_clk);
    chk("cleared pointer", 12'h000, fp);
    chk("cleared outputs", 12'h000, lo);
    master_clear_pin <= 1'b0;
    wait_load(12'h000, 1'b0);
    $display("test master clear done");
    test_done();
  end
endmodule : test_sfs_sequencer
